// [design/rac_defines.vh]
// Constants for the region attribute matcher and cache maintenance block.
`ifndef RAC_DEFINES_VH
`define RAC_DEFINES_VH

// ----------------------------------------------------------------------------
// Control register select codes on the control-move port
// ----------------------------------------------------------------------------
`define RAC_SEL_W 3
`define RAC_SEL_CACHE_CTL 3'h0
`define RAC_SEL_DATA_REGION_0 3'h1
`define RAC_SEL_DATA_REGION_1 3'h2
`define RAC_SEL_INSTR_REGION_0 3'h3
`define RAC_SEL_INSTR_REGION_1 3'h4

// ----------------------------------------------------------------------------
// Region register fields
// ----------------------------------------------------------------------------
`define RAC_RGN_BASE_HI 31
`define RAC_RGN_BASE_LO 24
`define RAC_RGN_MASK_HI 23
`define RAC_RGN_MASK_LO 16
`define RAC_RGN_ENABLE 15
`define RAC_RGN_PRIV_HI 14
`define RAC_RGN_PRIV_LO 13
`define RAC_RGN_MODE_HI 6
`define RAC_RGN_MODE_LO 5
`define RAC_RGN_WPROT 2
`define RAC_RGN_RESET 32'h0000_0000
`define RAC_DATA_RGN_KEEP 32'hffff_e064
`define RAC_INSTR_RGN_KEEP 32'hffff_e060
`define RAC_PRIV_USER 2'h0
`define RAC_PRIV_SUPER 2'h1
`define RAC_PRIV_ANY_BIT 1

// ----------------------------------------------------------------------------
// Cache mode encodings
// ----------------------------------------------------------------------------
`define RAC_MODE_WTHRU 2'h0
`define RAC_MODE_COPYBACK 2'h1
`define RAC_MODE_UNC_PRECISE 2'h2
`define RAC_MODE_UNC_IMPRECISE 2'h3

// ----------------------------------------------------------------------------
// Cache control register fields
// ----------------------------------------------------------------------------
`define RAC_CC_DATA_ON 31
`define RAC_CC_DATA_KEEP_VALID 28
`define RAC_CC_DATA_DEF_HI 26
`define RAC_CC_DATA_DEF_LO 25
`define RAC_CC_DATA_INV_ALL 24
`define RAC_CC_INSTR_ON 15
`define RAC_CC_INSTR_KEEP_VALID 12
`define RAC_CC_INSTR_DEF_MODE 10
`define RAC_CC_INSTR_INV_ALL 8
`define RAC_CC_KEEP 32'h9f00_9500
`define RAC_CC_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// Cache directory geometry and push operand layout
// ----------------------------------------------------------------------------
`define RAC_D_IDX_W 9
`define RAC_I_IDX_W 10
`define RAC_D_LINES 9'h1ff
`define RAC_I_LINES 10'h3ff
`define RAC_D_SET_HI 10
`define RAC_I_SET_HI 11
`define RAC_SET_LO 4
`define RAC_WAY_HI 1
`define RAC_WAY_LO 0

// ----------------------------------------------------------------------------
// Maintenance sequencer states
// ----------------------------------------------------------------------------
`define RAC_ST_W 2
`define RAC_ST_IDLE 2'h0
`define RAC_ST_PUSH 2'h1
`define RAC_ST_DINV 2'h2
`define RAC_ST_IINV 2'h3

`endif

// [design/rac_region_match.v]
// One region attribute register comparator.
`timescale 1ns/1ps
`include "rac_defines.vh"

module rac_region_match (
  input wire [31:0] region_attr_reg,
  input wire [7:0] addr_hi,
  input wire acc_super,
  output wire match,
  output wire [1:0] cache_mode_field,
  output wire wprot
);

  wire [7:0] base;
  wire [7:0] mask;
  wire [1:0] priv;
  wire priv_ok;

  // ----------------------------------------------------------------------------
  // Field extraction and comparison
  // ----------------------------------------------------------------------------
  assign base = region_attr_reg[`RAC_RGN_BASE_HI:`RAC_RGN_BASE_LO];
  assign mask = region_attr_reg[`RAC_RGN_MASK_HI:`RAC_RGN_MASK_LO];
  assign priv = region_attr_reg[`RAC_RGN_PRIV_HI:`RAC_RGN_PRIV_LO];

  // Filter 1x ignores privilege; 00 user only; 01 supervisor only.
  assign priv_ok = priv[`RAC_PRIV_ANY_BIT] | (priv == `RAC_PRIV_SUPER ? acc_super : ~acc_super);

  // Masked bits drop out of the compare, so one register can cover several regions.
  assign match = region_attr_reg[`RAC_RGN_ENABLE] & priv_ok & (((base ^ addr_hi) & ~mask) == 8'h00);
  assign cache_mode_field = region_attr_reg[`RAC_RGN_MODE_HI:`RAC_RGN_MODE_LO];
  assign wprot = region_attr_reg[`RAC_RGN_WPROT];

endmodule // rac_region_match

// [design/rac_valid_mem.v]
// Line valid-bit array for one cache directory, registered read port.
`timescale 1ns/1ps

module rac_valid_mem #(
  parameter ADDR_W = 9
) (
  input wire ref_clk,
  input wire ce,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire wr_data,
  input wire [ADDR_W-1:0] rd_addr,
  output reg rd_data
);

  reg mem [0:(1<<ADDR_W)-1];

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  // No reset on purpose: line state must survive a hardware reset.
  always @(posedge ref_clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule // rac_valid_mem

// [design/rac_top.v]
// Region attribute matcher and cache maintenance sequencer.
`timescale 1ns/1ps
`include "rac_defines.vh"

module rac_top (
  input wire ref_clk,
  input wire rst_b,
  input wire ce,
  input wire ctl_wr,
  input wire ctl_rd,
  input wire [`RAC_SEL_W-1:0] ctl_sel,
  input wire [31:0] ctl_wdata,
  output reg [31:0] ctl_rdata,
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire acc_instr,
  input wire acc_super,
  input wire acc_write,
  input wire onchip_ram_hit,
  output wire acc_stall,
  output reg res_valid,
  output reg res_region_hit,
  output reg [1:0] res_cache_mode,
  output reg res_write_fault,
  output reg res_cache_on,
  input wire push_req,
  input wire push_instr,
  input wire [31:0] push_operand_reg,
  output wire push_ready,
  output reg push_wb_valid,
  output reg [`RAC_D_IDX_W-1:0] push_wb_index,
  output reg push_done,
  input wire fill_valid,
  input wire fill_instr,
  input wire [`RAC_I_IDX_W-1:0] fill_index,
  output wire fill_ready,
  output wire data_cache_on,
  output wire instr_cache_on
);

  // ----------------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------------
  reg [31:0] cache_ctl_reg;
  reg [31:0] data_region_attr_0_reg;
  reg [31:0] data_region_attr_1_reg;
  reg [31:0] instr_region_attr_0_reg;
  reg [31:0] instr_region_attr_1_reg;
  reg [`RAC_ST_W-1:0] state_reg;
  reg [`RAC_I_IDX_W-1:0] inv_cnt_reg;
  reg push_instr_reg;
  reg [`RAC_I_IDX_W-1:0] push_idx_reg;

  wire [3:0] rgn_match;
  wire [1:0] rgn_mode [0:3];
  wire [3:0] rgn_wprot;
  wire [31:0] rgn_regs [0:3];
  wire d_rd_data;
  wire idle;
  wire inv_pending;
  wire ctl_take;
  wire push_take;
  wire fill_take;
  wire [`RAC_D_IDX_W-1:0] d_push_idx;
  wire [`RAC_I_IDX_W-1:0] i_push_idx;
  reg d_wr_en;
  reg [`RAC_D_IDX_W-1:0] d_wr_addr;
  reg d_wr_data;
  reg i_wr_en;
  reg [`RAC_I_IDX_W-1:0] i_wr_addr;
  reg i_wr_data;
  reg hit_next;
  reg [1:0] mode_next;
  reg fault_next;
  reg on_next;

  // ----------------------------------------------------------------------------
  // Region comparators, one per region register
  // ----------------------------------------------------------------------------
  assign rgn_regs[0] = data_region_attr_0_reg;
  assign rgn_regs[1] = data_region_attr_1_reg;
  assign rgn_regs[2] = instr_region_attr_0_reg;
  assign rgn_regs[3] = instr_region_attr_1_reg;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_rgn
      rac_region_match u_match (
        .region_attr_reg(rgn_regs[g]),
        .addr_hi(acc_addr[`RAC_RGN_BASE_HI:`RAC_RGN_BASE_LO]),
        .acc_super(acc_super),
        .match(rgn_match[g]),
        .cache_mode_field(rgn_mode[g]),
        .wprot(rgn_wprot[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Handshake terms
  // ----------------------------------------------------------------------------
  assign idle = (state_reg == `RAC_ST_IDLE);
  assign inv_pending = cache_ctl_reg[`RAC_CC_DATA_INV_ALL] | cache_ctl_reg[`RAC_CC_INSTR_INV_ALL];
  // Local accesses wait while an invalidate-all is pending or running.
  assign acc_stall = inv_pending;
  // Control writes are refused during a whole-cache invalidate so the self-clear cannot race them.
  assign ctl_take = ce & ctl_wr & ~inv_pending;
  assign push_ready = idle & ~inv_pending;
  assign push_take = ce & push_req & push_ready;
  assign fill_ready = idle & ~inv_pending & ~push_req;
  assign fill_take = ce & fill_valid & fill_ready;
  // Cache enables only gate service; maintenance never looks at them.
  assign data_cache_on = cache_ctl_reg[`RAC_CC_DATA_ON];
  assign instr_cache_on = cache_ctl_reg[`RAC_CC_INSTR_ON];

  // The operand is a directory index, not an address; upper bits are ignored.
  assign d_push_idx = {push_operand_reg[`RAC_D_SET_HI:`RAC_SET_LO],
                       push_operand_reg[`RAC_WAY_HI:`RAC_WAY_LO]};
  assign i_push_idx = {push_operand_reg[`RAC_I_SET_HI:`RAC_SET_LO],
                       push_operand_reg[`RAC_WAY_HI:`RAC_WAY_LO]};

  // ----------------------------------------------------------------------------
  // Attribute lookup, resolved combinationally in the access cycle
  // ----------------------------------------------------------------------------
  always @* begin
    hit_next = 1'b0;
    mode_next = `RAC_MODE_WTHRU;
    fault_next = 1'b0;
    on_next = 1'b0;
    if (acc_instr) begin
      on_next = instr_cache_on;
      if (rgn_match[2]) begin
        hit_next = 1'b1;
        mode_next = rgn_mode[2];
      end else if (rgn_match[3]) begin
        hit_next = 1'b1;
        mode_next = rgn_mode[3];
      end else if (!onchip_ram_hit) begin
        mode_next = cache_ctl_reg[`RAC_CC_INSTR_DEF_MODE] ? `RAC_MODE_UNC_PRECISE : `RAC_MODE_WTHRU;
      end
    end else begin
      on_next = data_cache_on;
      if (rgn_match[0]) begin
        hit_next = 1'b1;
        mode_next = rgn_mode[0];
        fault_next = acc_write & rgn_wprot[0];
      end else if (rgn_match[1]) begin
        hit_next = 1'b1;
        mode_next = rgn_mode[1];
        fault_next = acc_write & rgn_wprot[1];
      end else begin
        mode_next = cache_ctl_reg[`RAC_CC_DATA_DEF_HI:`RAC_CC_DATA_DEF_LO];
      end
    end
  end

  // Result is captured at the end of the access cycle; one stage keeps outputs clean.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      res_valid <= 1'b0;
      res_region_hit <= 1'b0;
      res_cache_mode <= `RAC_MODE_WTHRU;
      res_write_fault <= 1'b0;
      res_cache_on <= 1'b0;
    end else if (ce) begin
      res_valid <= acc_valid & ~acc_stall;
      res_region_hit <= hit_next;
      res_cache_mode <= mode_next;
      res_write_fault <= fault_next;
      res_cache_on <= on_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Control register reads
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_rdata <= 32'h0000_0000;
    end else if (ce && ctl_rd) begin
      case (ctl_sel)
        `RAC_SEL_CACHE_CTL: ctl_rdata <= cache_ctl_reg;
        `RAC_SEL_DATA_REGION_0: ctl_rdata <= data_region_attr_0_reg;
        `RAC_SEL_DATA_REGION_1: ctl_rdata <= data_region_attr_1_reg;
        `RAC_SEL_INSTR_REGION_0: ctl_rdata <= instr_region_attr_0_reg;
        `RAC_SEL_INSTR_REGION_1: ctl_rdata <= instr_region_attr_1_reg;
        default: ctl_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Region registers; reserved bits are never stored so they read zero
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_region_attr_0_reg <= `RAC_RGN_RESET;
      data_region_attr_1_reg <= `RAC_RGN_RESET;
      instr_region_attr_0_reg <= `RAC_RGN_RESET;
      instr_region_attr_1_reg <= `RAC_RGN_RESET;
    end else if (ctl_take) begin
      case (ctl_sel)
        `RAC_SEL_DATA_REGION_0: data_region_attr_0_reg <= ctl_wdata & `RAC_DATA_RGN_KEEP;
        `RAC_SEL_DATA_REGION_1: data_region_attr_1_reg <= ctl_wdata & `RAC_DATA_RGN_KEEP;
        `RAC_SEL_INSTR_REGION_0: instr_region_attr_0_reg <= ctl_wdata & `RAC_INSTR_RGN_KEEP;
        `RAC_SEL_INSTR_REGION_1: instr_region_attr_1_reg <= ctl_wdata & `RAC_INSTR_RGN_KEEP;
        default: data_region_attr_0_reg <= data_region_attr_0_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Cache control register and maintenance sequencer
  // ----------------------------------------------------------------------------
  // Reset clears this register and the sequencer state; the valid arrays have no reset at all.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cache_ctl_reg <= `RAC_CC_RESET;
      state_reg <= `RAC_ST_IDLE;
      inv_cnt_reg <= {`RAC_I_IDX_W{1'b0}};
      push_instr_reg <= 1'b0;
      push_idx_reg <= {`RAC_I_IDX_W{1'b0}};
      push_wb_valid <= 1'b0;
      push_wb_index <= {`RAC_D_IDX_W{1'b0}};
      push_done <= 1'b0;
    end else if (ce) begin
      push_wb_valid <= 1'b0;
      push_done <= 1'b0;
      if (ctl_take && ctl_sel == `RAC_SEL_CACHE_CTL) begin
        cache_ctl_reg <= ctl_wdata & `RAC_CC_KEEP;
      end
      case (state_reg)
        `RAC_ST_IDLE: begin
          // Invalidate-all runs regardless of the enable bits.
          if (cache_ctl_reg[`RAC_CC_DATA_INV_ALL]) begin
            state_reg <= `RAC_ST_DINV;
            inv_cnt_reg <= {`RAC_I_IDX_W{1'b0}};
          end else if (cache_ctl_reg[`RAC_CC_INSTR_INV_ALL]) begin
            state_reg <= `RAC_ST_IINV;
            inv_cnt_reg <= {`RAC_I_IDX_W{1'b0}};
          end else if (push_take) begin
            state_reg <= `RAC_ST_PUSH;
            push_instr_reg <= push_instr;
            push_idx_reg <= push_instr ? i_push_idx : {1'b0, d_push_idx};
          end
        end
        `RAC_ST_PUSH: begin
          // Only data lines can hold anything to write back.
          push_wb_valid <= ~push_instr_reg & d_rd_data;
          push_wb_index <= push_idx_reg[`RAC_D_IDX_W-1:0];
          push_done <= 1'b1;
          state_reg <= `RAC_ST_IDLE;
        end
        `RAC_ST_DINV: begin
          inv_cnt_reg <= inv_cnt_reg + 10'h001;
          if (inv_cnt_reg[`RAC_D_IDX_W-1:0] == `RAC_D_LINES) begin
            cache_ctl_reg[`RAC_CC_DATA_INV_ALL] <= 1'b0;
            state_reg <= `RAC_ST_IDLE;
          end
        end
        `RAC_ST_IINV: begin
          inv_cnt_reg <= inv_cnt_reg + 10'h001;
          if (inv_cnt_reg == `RAC_I_LINES) begin
            cache_ctl_reg[`RAC_CC_INSTR_INV_ALL] <= 1'b0;
            state_reg <= `RAC_ST_IDLE;
          end
        end
        default: state_reg <= `RAC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Valid-array write steering: invalidate sweep, push clear, line fill
  // ----------------------------------------------------------------------------
  always @* begin
    d_wr_en = 1'b0;
    d_wr_addr = push_idx_reg[`RAC_D_IDX_W-1:0];
    d_wr_data = 1'b0;
    i_wr_en = 1'b0;
    i_wr_addr = push_idx_reg;
    i_wr_data = 1'b0;
    if (state_reg == `RAC_ST_DINV) begin
      d_wr_en = 1'b1;
      d_wr_addr = inv_cnt_reg[`RAC_D_IDX_W-1:0];
    end else if (state_reg == `RAC_ST_IINV) begin
      i_wr_en = 1'b1;
      i_wr_addr = inv_cnt_reg;
    end else if (state_reg == `RAC_ST_PUSH) begin
      d_wr_en = ~push_instr_reg & ~cache_ctl_reg[`RAC_CC_DATA_KEEP_VALID];
      i_wr_en = push_instr_reg & ~cache_ctl_reg[`RAC_CC_INSTR_KEEP_VALID];
    end else if (fill_take) begin
      d_wr_en = ~fill_instr;
      d_wr_addr = fill_index[`RAC_D_IDX_W-1:0];
      d_wr_data = 1'b1;
      i_wr_en = fill_instr;
      i_wr_addr = fill_index;
      i_wr_data = 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Directory valid arrays
  // ----------------------------------------------------------------------------
  rac_valid_mem #(
    .ADDR_W(`RAC_D_IDX_W)
  ) u_data_valid (
    .ref_clk(ref_clk),
    .ce(ce),
    .wr_en(d_wr_en),
    .wr_addr(d_wr_addr),
    .wr_data(d_wr_data),
    .rd_addr(d_push_idx),
    .rd_data(d_rd_data)
  );

  // Instruction lines never hold anything to write back, so their read port is left open.
  rac_valid_mem #(
    .ADDR_W(`RAC_I_IDX_W)
  ) u_instr_valid (
    .ref_clk(ref_clk),
    .ce(ce),
    .wr_en(i_wr_en),
    .wr_addr(i_wr_addr),
    .wr_data(i_wr_data),
    .rd_addr(i_push_idx),
    .rd_data()
  );

endmodule // rac_top

// [tb/rac_core_model.sv]
// Processor core model issuing control moves, accesses, line pushes and fills.
`timescale 1ns/1ps

module rac_core_model (
  input wire ref_clk,
  input wire push_ready,
  input wire fill_ready,
  output logic ctl_wr,
  output logic ctl_rd,
  output logic [2:0] ctl_sel,
  output logic [31:0] ctl_wdata,
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic acc_instr,
  output logic acc_super,
  output logic acc_write,
  output logic onchip_ram_hit,
  output logic push_req,
  output logic push_instr,
  output logic [31:0] push_operand_reg,
  output logic fill_valid,
  output logic fill_instr,
  output logic [9:0] fill_index
);
  // ----------------------------------------
  // Idle buses
  // ----------------------------------------
  // Everything starts quiet so the first request follows reset release.
  initial begin
    {ctl_wr, ctl_rd, ctl_sel, ctl_wdata, acc_valid, acc_addr, acc_instr} = '0;
    {acc_super, acc_write, onchip_ram_hit, push_req, push_instr, push_operand_reg} = '0;
    {fill_valid, fill_instr, fill_index} = '0;
  end

  // ----------------------------------------
  // Requests
  // ----------------------------------------
  // Words move whole; released data is inverted so a stale value never looks fresh.
  task automatic ctl_write(input logic [2:0] sel, input logic [31:0] data);
    @(posedge ref_clk);
    ctl_wr <= 1'b1;
    ctl_sel <= sel;
    ctl_wdata <= data;
    @(posedge ref_clk);
    ctl_wr <= 1'b0;
    ctl_wdata <= ~data;
  endtask

  task automatic ctl_read(input logic [2:0] sel);
    @(posedge ref_clk);
    ctl_rd <= 1'b1;
    ctl_sel <= sel;
    @(posedge ref_clk);
    ctl_rd <= 1'b0;
  endtask

  task automatic access(input logic ins, input logic sup, input logic wr, input logic ram, input logic [31:0] a);
    @(posedge ref_clk);
    {acc_valid, acc_instr, acc_super, acc_write, onchip_ram_hit, acc_addr} <= {1'b1, ins, sup, wr, ram, a};
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
  endtask

  // Push and fill hold their request until ready is seen before the taking edge.
  task automatic push(input logic [31:0] op, input logic ins);
    @(posedge ref_clk);
    {push_req, push_instr, push_operand_reg} <= {1'b1, ins, op};
    @(negedge ref_clk);
    while (push_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    push_req <= 1'b0;
    push_operand_reg <= ~op;
  endtask

  task automatic fill(input logic [9:0] idx, input logic ins);
    @(posedge ref_clk);
    {fill_valid, fill_instr, fill_index} <= {1'b1, ins, idx};
    @(negedge ref_clk);
    while (fill_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    fill_valid <= 1'b0;
    fill_index <= ~idx;
  endtask
endmodule // rac_core_model

// [tb/rac_top_assertions.sv]
// Concurrent checks on the ports of the region attribute and cache maintenance block.
`timescale 1ns/1ps

module rac_top_checker (
  input wire ref_clk,
  input wire rst_b,
  input wire ctl_rd,
  input wire [2:0] ctl_sel,
  input wire [31:0] ctl_rdata,
  input wire acc_valid,
  input wire acc_instr,
  input wire acc_write,
  input wire acc_stall,
  input wire res_valid,
  input wire res_write_fault,
  input wire push_req,
  input wire push_ready,
  input wire push_done,
  input wire push_wb_valid,
  input wire fill_ready,
  input wire data_cache_on,
  input wire instr_cache_on
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  reg [11:0] stall_cnt_reg;

  // Counts stall cycles, since a long repetition would choke the tools.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) stall_cnt_reg <= 12'h000;
    else stall_cnt_reg <= acc_stall ? stall_cnt_reg + 12'h001 : 12'h000;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_push_taken;
    push_req && push_ready;
  endsequence
  sequence s_push_answer;
    !push_ready ##1 push_done;
  endsequence

  a_push_answer: assert property (s_push_taken |=> s_push_answer)
    else $error("push not answered in two cycles");
  a_wb_with_done: assert property (push_wb_valid |-> push_done)
    else $error("write back without push end");
  a_data_rd_zero: assert property (ctl_rd && (ctl_sel == 3'h1 || ctl_sel == 3'h2) |=> (ctl_rdata & 32'h0000_1f9b) == 0)
    else $error("data region reserved bits read nonzero");
  a_instr_rd_zero: assert property (ctl_rd && (ctl_sel == 3'h3 || ctl_sel == 3'h4) |=> (ctl_rdata & 32'h0000_1f9f) == 0)
    else $error("instr region reserved bits read nonzero");
  a_reset_caches_off: assert property ($rose(rst_b) |-> !data_cache_on && !instr_cache_on)
    else $error("cache on after reset");
  a_stall_no_result: assert property (res_valid |-> $past(acc_valid && !acc_stall))
    else $error("result without unstalled access");
  a_stall_blocks: assert property (acc_stall |-> !push_ready && !fill_ready)
    else $error("push or fill open while stalled");
  a_enables_held: assert property (acc_stall |=> $stable(data_cache_on) && $stable(instr_cache_on))
    else $error("enable changed during sweep");
  a_fault_on_write: assert property (res_valid && res_write_fault |-> $past(acc_write && !acc_instr))
    else $error("write fault without data write");
  a_sweep_length: assert property ($fell(acc_stall) |-> stall_cnt_reg >= 12'h200 && stall_cnt_reg <= 12'h604)
    else $error("invalidate sweep length wrong");
endmodule // rac_top_checker

bind rac_top rac_top_checker u_rac_top_checker (.*);

// [tb/testbench.sv]
// Self-checking testbench for the region attribute and cache maintenance block.
`timescale 1ns/1ps

module testbench;
  logic ref_clk, rst_b, ce, ctl_wr, ctl_rd, acc_valid, acc_instr, acc_super, acc_write, onchip_ram_hit;
  logic acc_stall, res_valid, res_region_hit, res_write_fault, res_cache_on, push_req, push_instr;
  logic push_ready, push_wb_valid, push_done, fill_valid, fill_instr, fill_ready, data_cache_on, instr_cache_on;
  logic [2:0] ctl_sel;
  logic [31:0] ctl_wdata, ctl_rdata, acc_addr, push_operand_reg;
  logic [1:0] res_cache_mode;
  logic [8:0] push_wb_index;
  logic [9:0] fill_index;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  // Rows: instr, super, write, ram hit, address byte, expected hit, mode, fault.
  logic [15:0] rows [10] = '{16'h210b, 16'h410a, 16'h41fc, 16'h01f6, 16'h2506,
                             16'h820e, 16'hc204, 16'h8304, 16'h9440, 16'h61fc};
  // Region words as written, two with reserved bits set, and as they read back.
  logic [31:0] rgn_wr [4] = '{32'h1000_dfbf, 32'h100f_a040, 32'h2000_8064, 32'h3000_4020};
  logic [31:0] rgn_rd [4] = '{32'h1000_c024, 32'h100f_a040, 32'h2000_8060, 32'h3000_4020};

  rac_top u_rac_top (.*);
  rac_core_model u_rac_core_model (.*);

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Two sweeps of at most 1540 cycles plus a few hundred of traffic fit well inside this.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic read_check(input logic [2:0] sel, input logic [31:0] exp);
    u_rac_core_model.ctl_read(sel);
    @(negedge ref_clk);
    check(ctl_rdata, exp);
  endtask

  task automatic access_check(input logic [15:0] r, input logic on);
    u_rac_core_model.access(r[15], r[14], r[13], r[12], {r[11:4], 24'h5a_5a5a});
    @(negedge ref_clk);
    check({26'h0, res_valid, res_region_hit, res_cache_mode, res_write_fault, res_cache_on}, {26'h0, 1'b1, r[3:0], on});
  endtask

  // The write-back index is only meaningful when a write-back is flagged.
  task automatic push_check(input logic [31:0] op, input logic ins, input logic [10:0] exp);
    u_rac_core_model.push(op, ins);
    repeat (2) @(negedge ref_clk);
    if (exp[9]) check({21'h0, push_done, push_wb_valid, push_wb_index}, {21'h0, exp});
    else check({30'h0, push_done, push_wb_valid}, {30'h0, exp[10:9]});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int s = 0; s < 8; s++) read_check(3'(s), 32'h0000_0000);
    check({30'h0, data_cache_on, instr_cache_on}, 32'h0000_0000);
    // Invalidate both caches first; a write and an access during the sweep are refused.
    u_rac_core_model.ctl_write(3'h0, 32'h0100_0100);
    u_rac_core_model.ctl_write(3'h0, 32'h8000_8000);
    u_rac_core_model.access(1'b0, 1'b1, 1'b0, 1'b0, 32'h1000_0000);
    @(negedge ref_clk);
    check({30'h0, res_valid, acc_stall}, 32'h0000_0001);
    @(negedge ref_clk);
    for (int i = 0; i < 2000 && acc_stall === 1'b1; i++) @(negedge ref_clk);
    read_check(3'h0, 32'h0000_0000);
    for (int r = 0; r < 4; r++) begin
      u_rac_core_model.ctl_write(3'(r + 1), rgn_wr[r]);
      read_check(3'(r + 1), rgn_rd[r]);
    end
    u_rac_core_model.ctl_write(3'h0, 32'h8600_8400);
    @(negedge ref_clk);
    check({30'h0, data_cache_on, instr_cache_on}, 32'h0000_0003);
    for (int r = 0; r < 10; r++) access_check(rows[r], 1'b1);
    // A valid line is written back and dropped, so a second push finds nothing.
    u_rac_core_model.fill(10'h016, 1'b0);
    push_check(32'h0000_0052, 1'b0, {2'b11, 9'h016});
    push_check(32'h0000_0052, 1'b0, {2'b10, 9'h016});
    // Keep-valid set and data cache off: the last line survives two pushes.
    u_rac_core_model.ctl_write(3'h0, 32'h1000_8400);
    u_rac_core_model.fill(10'h1ff, 1'b0);
    push_check(32'h0000_07f3, 1'b0, {2'b11, 9'h1ff});
    push_check(32'h0000_07f3, 1'b0, {2'b11, 9'h1ff});
    access_check(rows[1], 1'b0);
    push_check(32'h0000_0ff3, 1'b1, {2'b10, 9'h000});
    // Reset in mid-run clears control but leaves the kept line valid; a frozen write is lost.
    @(posedge ref_clk) rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    ce <= 1'b0;
    u_rac_core_model.ctl_write(3'h0, 32'h8000_8000);
    ce <= 1'b1;
    read_check(3'h0, 32'h0000_0000);
    push_check(32'h0000_07f3, 1'b0, {2'b11, 9'h1ff});
    report_and_stop();
  end
endmodule // testbench
